// File: logic/spl_pkg.sv
// Purpose: Constants for the system PLL configuration and lock monitor.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes:   Offsets, fields, reset values and timing counts live here.
package spl_pkg;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00; // Doubler, divider, apply
  localparam logic [7:0] ADDR_FREQ_LO = 8'h04; // Numerator bits 31:0
  localparam logic [7:0] ADDR_FREQ_HI = 8'h08; // Numerator 47:32, denominator
  localparam logic [7:0] ADDR_STATUS  = 8'h0c; // Lock state and load source
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h10; // Sticky events, write one clears
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h14; // Interrupt enables
  localparam logic [7:0] ADDR_GPO_CFG = 8'h18; // Loss-of-lock pin routing

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int NUM_W     = 48;
  localparam int DEN_W     = 16;
  localparam int FBDIV_W   = 10;
  localparam int CTRL_DBL  = 0;
  localparam int CTRL_DIV0 = 1;
  localparam int CTRL_DIVN = 10;
  localparam int CTRL_APPLY = 31;
  localparam int IRQ_W     = 4;
  localparam int EV_LOSS   = 0; // Lock lost
  localparam int EV_LOCK   = 1; // Lock gained
  localparam int EV_BADDIV = 2; // Divider out of range refused
  localparam int EV_NOSRC  = 3; // No valid boot source

  // ****************************************************************
  // Legal range and reset values
  // ****************************************************************
  localparam logic [FBDIV_W-1:0] FBDIV_MIN = 10'h06c; // 108
  localparam logic [FBDIV_W-1:0] FBDIV_MAX = 10'h22c; // 556
  localparam logic [FBDIV_W-1:0] FBDIV_RST = 10'h06c;
  localparam logic [DEN_W-1:0]   DEN_RST   = 16'h0001;

  // Lock window around the expected control code, in code units
  localparam logic [11:0] VC_MARGIN = 12'h020;
  localparam logic [11:0] VC_BASE   = 12'h100;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ    = 200;
  localparam int SETTLE_NS  = 1000; // Loop settle time after apply
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    SPL_BOOT_WAIT,
    SPL_BOOT_OTP,
    SPL_BOOT_EEP,
    SPL_SETTLE,
    SPL_RUN
  } spl_state_e;

endpackage

// File: logic/spl_sys_pll_ctl.sv
// Purpose: Digital control and lock monitor for the system analog PLL.
// Assumes: One clock, ref_clk at 200 MHz; boot sources are on the same clock.
// Notes:   Loop control voltage arrives as an ADC code from another domain.
`timescale 1ns/1ps

module spl_sys_pll_ctl (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        otp_enable,
  input  wire logic        otp_valid,
  input  wire logic [63:0] otp_freq,
  input  wire logic        otp_doubler,
  input  wire logic [9:0]  otp_fbdiv,
  input  wire logic        eep_enable,
  input  wire logic        eep_valid,
  input  wire logic [63:0] eep_freq,
  input  wire logic        eep_doubler,
  input  wire logic [9:0]  eep_fbdiv,
  input  wire logic        boot_done,
  input  wire logic [11:0] loop_vc_code,
  output logic             pll_doubler_en,
  output logic      [9:0]  pll_fbdiv,
  output logic      [47:0] pll_freq_num,
  output logic      [15:0] pll_freq_den,
  output logic             lol_alarm,
  output logic             gpo_lol,
  output logic             irq
);

  // ****************************************************************
  // Synchronisers for inputs from outside the clock domain
  // ****************************************************************
  logic [11:0] vc_s1_q, vc_s2_q, vc_s3_q;
  logic        bd_s1_q, bd_s2_q;

  // Two stages; first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vc_s1_q <= 12'h000;
      vc_s2_q <= 12'h000;
      vc_s3_q <= 12'h000;
      bd_s1_q <= 1'b0;
      bd_s2_q <= 1'b0;
    end
    else
    begin
      vc_s1_q <= loop_vc_code;
      vc_s2_q <= vc_s1_q;
      vc_s3_q <= vc_s2_q; // Compare stage, after the synchroniser
      bd_s1_q <= boot_done;
      bd_s2_q <= bd_s1_q;
    end
  end

  // ****************************************************************
  // State
  // ****************************************************************
  spl_pkg::spl_state_e state_q, state_d;
  logic                     dbl_q, dbl_d;
  logic [9:0]               div_q, div_d;
  logic [47:0]              num_q, num_d;
  logic [15:0]              den_q, den_d;
  logic                     st_dbl_q, st_dbl_d;   // Staged, not yet applied
  logic [9:0]               st_div_q, st_div_d;
  logic [47:0]              st_num_q, st_num_d;
  logic [15:0]              st_den_q, st_den_d;
  logic                     lock_q, lock_d;
  logic                     src_q, src_d;        // 1 = loaded from EEPROM
  logic                     gpo_en_q, gpo_en_d;
  logic [spl_pkg::IRQ_W-1:0] ist_q, ist_d, msk_q, msk_d;
  logic [7:0]               cnt_q, cnt_d;
  logic [31:0]              rdata_q, rdata_d;
  logic                     rd_ack_q, rd_ack_d;   // Read data stands in rdata_q

  logic        wr, rd, vc_ok, apply_ok, apply_bad;
  logic [11:0] vc_exp;
  logic [spl_pkg::IRQ_W-1:0] ev;

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  // Expected control code from divider and doubler; no user limits needed
  assign vc_exp = spl_pkg::VC_BASE + {2'b00, div_q} + {11'h000, dbl_q};
  assign vc_ok  = (vc_s2_q >= vc_exp - spl_pkg::VC_MARGIN) &&
                  (vc_s2_q <= vc_exp + spl_pkg::VC_MARGIN);

  // Apply bit with a legal divider in the same write takes effect; others refused
  assign apply_ok  = wr && (paddr == spl_pkg::ADDR_CTRL) && pwdata[spl_pkg::CTRL_APPLY] &&
                     (pwdata[spl_pkg::CTRL_DIVN:spl_pkg::CTRL_DIV0] >= spl_pkg::FBDIV_MIN) &&
                     (pwdata[spl_pkg::CTRL_DIVN:spl_pkg::CTRL_DIV0] <= spl_pkg::FBDIV_MAX);
  assign apply_bad = wr && (paddr == spl_pkg::ADDR_CTRL) && pwdata[spl_pkg::CTRL_APPLY] &&
                     !apply_ok;

  // ****************************************************************
  // Configuration, boot load and lock tracking
  // ****************************************************************
  always_comb
  begin
    state_d  = state_q;
    dbl_d    = dbl_q;
    div_d    = div_q;
    num_d    = num_q;
    den_d    = den_q;
    st_dbl_d = st_dbl_q;
    st_div_d = st_div_q;
    st_num_d = st_num_q;
    st_den_d = st_den_q;
    lock_d   = lock_q;
    src_d    = src_q;
    cnt_d    = cnt_q;
    ev       = '0;
    unique case (state_q)
      spl_pkg::SPL_BOOT_WAIT:
        if (bd_s2_q)
        begin
          // OTP has priority when both are usable
          if (otp_enable && otp_valid)
            state_d = spl_pkg::SPL_BOOT_OTP;
          else if (eep_enable && eep_valid)
            state_d = spl_pkg::SPL_BOOT_EEP;
          else
          begin
            ev[spl_pkg::EV_NOSRC] = 1'b1;
            state_d = spl_pkg::SPL_SETTLE;  // Keep reset defaults
            cnt_d   = 8'(spl_pkg::SETTLE_CYC);
          end
        end
      spl_pkg::SPL_BOOT_OTP:
      begin
        dbl_d   = otp_doubler;
        div_d   = otp_fbdiv;
        num_d   = otp_freq[63:16];
        den_d   = otp_freq[15:0];
        src_d   = 1'b0;
        state_d = spl_pkg::SPL_SETTLE;
        cnt_d   = 8'(spl_pkg::SETTLE_CYC);
      end
      spl_pkg::SPL_BOOT_EEP:
      begin
        dbl_d   = eep_doubler;
        div_d   = eep_fbdiv;
        num_d   = eep_freq[63:16];
        den_d   = eep_freq[15:0];
        src_d   = 1'b1;
        state_d = spl_pkg::SPL_SETTLE;
        cnt_d   = 8'(spl_pkg::SETTLE_CYC);
      end
      spl_pkg::SPL_SETTLE:
      begin
        // Lock is not judged while the loop re-acquires
        lock_d = 1'b0;
        if (cnt_q != 8'h00)
          cnt_d = cnt_q - 8'h01;
        else
          state_d = spl_pkg::SPL_RUN;
      end
      spl_pkg::SPL_RUN:
        // Code bits cross unaligned; judge only a code seen twice alike
        if (vc_s2_q == vc_s3_q)
          lock_d = vc_ok;
      default:
        state_d = spl_pkg::SPL_BOOT_WAIT;
    endcase
    // Staging writes are held until an apply
    if (wr && paddr == spl_pkg::ADDR_FREQ_LO)
      st_num_d[31:0] = pwdata;
    if (wr && paddr == spl_pkg::ADDR_FREQ_HI)
    begin
      st_num_d[47:32] = pwdata[15:0];
      st_den_d        = pwdata[31:16];
    end
    if (wr && paddr == spl_pkg::ADDR_CTRL)
    begin
      st_dbl_d = pwdata[spl_pkg::CTRL_DBL];
      st_div_d = pwdata[spl_pkg::CTRL_DIVN:spl_pkg::CTRL_DIV0];
    end
    // Host reconfiguration only after boot load has finished
    if (apply_ok && (state_q == spl_pkg::SPL_RUN || state_q == spl_pkg::SPL_SETTLE))
    begin
      dbl_d   = pwdata[spl_pkg::CTRL_DBL];
      div_d   = pwdata[spl_pkg::CTRL_DIVN:spl_pkg::CTRL_DIV0];
      num_d   = st_num_q;
      den_d   = st_den_q;
      lock_d  = 1'b0;
      state_d = spl_pkg::SPL_SETTLE;
      cnt_d   = 8'(spl_pkg::SETTLE_CYC);
    end
    if (apply_bad)
      ev[spl_pkg::EV_BADDIV] = 1'b1;
    ev[spl_pkg::EV_LOSS] = lock_q && !lock_d;
    ev[spl_pkg::EV_LOCK] = !lock_q && lock_d;
  end

  // ****************************************************************
  // Interrupt and register file
  // ****************************************************************
  always_comb
  begin
    ist_d    = ist_q;
    msk_d    = msk_q;
    gpo_en_d = gpo_en_q;
    rdata_d  = rdata_q;
    rd_ack_d = rd && !rd_ack_q;
    if (wr && paddr == spl_pkg::ADDR_IRQ_ST)
      ist_d = ist_q & ~pwdata[spl_pkg::IRQ_W-1:0];
    // Set after clear so a same-cycle event survives
    ist_d = ist_d | ev;
    if (wr && paddr == spl_pkg::ADDR_IRQ_MSK)
      msk_d = pwdata[spl_pkg::IRQ_W-1:0];
    if (wr && paddr == spl_pkg::ADDR_GPO_CFG)
      gpo_en_d = pwdata[0];
    // Capture on the first access edge; the wait state shows it from a flop
    if (rd && !rd_ack_q)
    begin
      unique case (paddr)
        spl_pkg::ADDR_CTRL:    rdata_d = {21'h000000, div_q, dbl_q};
        spl_pkg::ADDR_FREQ_LO: rdata_d = num_q[31:0];
        spl_pkg::ADDR_FREQ_HI: rdata_d = {den_q, num_q[47:32]};
        spl_pkg::ADDR_STATUS:  rdata_d = {28'h0000000, src_q,
                                          state_q == spl_pkg::SPL_RUN, !lock_q, lock_q};
        spl_pkg::ADDR_IRQ_ST:  rdata_d = {28'h0000000, ist_q};
        spl_pkg::ADDR_IRQ_MSK: rdata_d = {28'h0000000, msk_q};
        spl_pkg::ADDR_GPO_CFG: rdata_d = {31'h00000000, gpo_en_q};
        default:               rdata_d = 32'h00000000;
      endcase
    end
  end

  // Register all state apart from the synchronisers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q  <= spl_pkg::SPL_BOOT_WAIT;
      dbl_q    <= 1'b0;
      div_q    <= spl_pkg::FBDIV_RST;
      num_q    <= 48'h000000000000;
      den_q    <= spl_pkg::DEN_RST;
      st_dbl_q <= 1'b0;
      st_div_q <= spl_pkg::FBDIV_RST;
      st_num_q <= 48'h000000000000;
      st_den_q <= spl_pkg::DEN_RST;
      lock_q   <= 1'b0;
      src_q    <= 1'b0;
      gpo_en_q <= 1'b0;
      ist_q    <= 4'h0;
      msk_q    <= 4'h0;
      cnt_q    <= 8'h00;
      rdata_q  <= 32'h00000000;
      rd_ack_q <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      dbl_q    <= dbl_d;
      div_q    <= div_d;
      num_q    <= num_d;
      den_q    <= den_d;
      st_dbl_q <= st_dbl_d;
      st_div_q <= st_div_d;
      st_num_q <= st_num_d;
      st_den_q <= st_den_d;
      lock_q   <= lock_d;
      src_q    <= src_d;
      gpo_en_q <= gpo_en_d;
      ist_q    <= ist_d;
      msk_q    <= msk_d;
      cnt_q    <= cnt_d;
      rdata_q  <= rdata_d;
      rd_ack_q <= rd_ack_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Reads take one wait state so read data comes straight from a flop
  assign pready         = !rd || rd_ack_q;
  assign pslverr        = 1'b0;
  assign prdata         = rdata_q;
  assign pll_doubler_en = dbl_q;
  assign pll_fbdiv      = div_q;
  assign pll_freq_num   = num_q;
  assign pll_freq_den   = den_q;
  assign lol_alarm      = !lock_q;
  assign gpo_lol        = gpo_en_q && !lock_q;
  assign irq            = |(ist_q & msk_q);

endmodule // spl_sys_pll_ctl

// File: test/spl_boot_model.sv
// Purpose: Boot stores and loop voltage source for the PLL block.
// Assumes: src_mode bit0 OTP valid, bit1 EEPROM valid.
// Notes:   Contents stay stable while boot_done rises.
`timescale 1ns/1ps
module spl_boot_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  src_mode,
  input  wire logic [11:0] vc_set,
  output logic             otp_enable,
  output logic             otp_valid,
  output logic      [63:0] otp_freq,
  output logic             otp_doubler,
  output logic      [9:0]  otp_fbdiv,
  output logic             eep_enable,
  output logic             eep_valid,
  output logic      [63:0] eep_freq,
  output logic             eep_doubler,
  output logic      [9:0]  eep_fbdiv,
  output logic             boot_done,
  output logic      [11:0] loop_vc_code
);
  logic [1:0] cnt_q;
  // Store contents; divider picks an in-window loop rate
  assign otp_enable   = 1'b1;
  assign eep_enable   = 1'b1;
  assign otp_valid    = src_mode[0];
  assign eep_valid    = src_mode[1];
  assign otp_freq     = 64'h0000_1234_5678_0009;
  assign otp_doubler  = 1'b1;
  assign otp_fbdiv    = 10'h0c8;
  assign eep_freq     = 64'h0abc_0000_0001_0002;
  assign eep_doubler  = 1'b0;
  assign eep_fbdiv    = 10'h190;
  assign loop_vc_code = vc_set;
  assign boot_done    = cnt_q == 2'h3;
  // Stores report ready a few cycles after reset
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 2'h0;
    else if (cnt_q != 2'h3)
      cnt_q <= cnt_q + 2'h1;
  end
endmodule // spl_boot_model

// File: test/spl_sys_pll_props.sv
// Purpose: Checks on the PLL control block ports.
// Assumes: One clock; applies spaced past the settle time.
// Notes:   since_q counts cycles from reset or a legal apply.
`timescale 1ns/1ps
module spl_sys_pll_props (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [11:0] loop_vc_code,
  input wire logic        pll_doubler_en,
  input wire logic [9:0]  pll_fbdiv,
  input wire logic [47:0] pll_freq_num,
  input wire logic [15:0] pll_freq_den,
  input wire logic        lol_alarm,
  input wire logic        gpo_lol,
  input wire logic        irq
);
  logic [9:0]  since_q;
  logic [9:0]  since_d;
  logic [9:0]  div_w;
  logic        apply_w;
  logic        legal_w;
  logic [11:0] exp_w;
  logic [11:0] dif_w;
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  assign div_w   = pwdata[10:1];
  assign legal_w = div_w >= 10'h06c && div_w <= 10'h22c;
  assign apply_w = psel && penable && pwrite && paddr == spl_pkg::ADDR_CTRL && pwdata[31];
  assign exp_w   = spl_pkg::VC_BASE + {2'h0, pll_fbdiv} + {11'h0, pll_doubler_en};
  assign dif_w   = loop_vc_code >= exp_w ? loop_vc_code - exp_w : exp_w - loop_vc_code;
  // Saturating counter; only legal applies more than 230 cycles after the last restart restart it
  always_comb
  begin
    since_d = (since_q == 10'h3ff) ? since_q : since_q + 10'h001;
    if (apply_w && legal_w && since_q > 10'd230)
      since_d = 10'h000;
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      since_q <= 10'h000;
    else
      since_q <= since_d;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_early_alarm: assert property (since_q < 10'd200 |-> lol_alarm)
    else $error("alarm low before first lock");
  a_div_range: assert property (pll_fbdiv >= 10'h06c && pll_fbdiv <= 10'h22c)
    else $error("divider out of range");
  a_div_refuse: assert property (apply_w && !legal_w |=> $stable(pll_fbdiv))
    else $error("illegal divider applied");
  a_apply_load: assert property (apply_w && legal_w && since_q > 10'd230 |=>
    pll_fbdiv == $past(div_w) && pll_doubler_en == $past(pwdata[0]))
    else $error("apply not taken");
  a_apply_unlock: assert property (apply_w && legal_w && since_q > 10'd230 |=> lol_alarm[*8])
    else $error("no alarm while settling");
  a_cfg_change: assert property ((!$stable(pll_fbdiv) || !$stable(pll_freq_num) ||
    !$stable(pll_freq_den)) && $past(since_q) > 10'd230 |-> since_q == 10'h000)
    else $error("config changed without apply");
  a_lock_window: assert property ((since_q > 10'd230 && $stable(loop_vc_code))[*5] |->
    lol_alarm == (dif_w > spl_pkg::VC_MARGIN))
    else $error("lock state wrong for code");
  a_gpo_route: assert property (gpo_lol |-> lol_alarm)
    else $error("pin shows loss while locked");
  c_apply: cover property (apply_w && legal_w);
  c_loss: cover property ($rose(lol_alarm));
  c_gpo: cover property (gpo_lol);
  c_irq: cover property (irq);
endmodule // spl_sys_pll_props
bind spl_sys_pll_ctl spl_sys_pll_props chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .loop_vc_code(loop_vc_code), .pll_doubler_en(pll_doubler_en), .pll_fbdiv(pll_fbdiv),
  .pll_freq_num(pll_freq_num), .pll_freq_den(pll_freq_den), .lol_alarm(lol_alarm),
  .gpo_lol(gpo_lol), .irq(irq));

// File: test/system_pll_config_lock_monitor_tb.sv
// Purpose: Register-level tests of the PLL control block.
// Assumes: APB reads wait one cycle, writes none; boot and settle fit in 240 cycles.
// Notes:   Applies are spaced by 240 cycles to let the loop settle.
`timescale 1ns/1ps
module system_pll_config_lock_monitor_tb;
  logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd_v;
  logic err_v;
  logic pready, pslverr, otp_enable, otp_valid, otp_doubler, eep_enable, eep_valid;
  logic eep_doubler, boot_done, pll_doubler_en, lol_alarm, gpo_lol, irq;
  logic [63:0] otp_freq, eep_freq;
  logic [9:0] otp_fbdiv, eep_fbdiv, pll_fbdiv, exp_div;
  logic [11:0] loop_vc_code, vc_set = 12'h1c9;
  logic [47:0] pll_freq_num;
  logic [15:0] pll_freq_den;
  logic [1:0] src_mode = 2'h1;
  int mismatches = 0, checks_done = 0;
  logic [9:0] divs [4] = '{10'd107, 10'd108, 10'd557, 10'd556};
  // ****************************************************************
  // Clock, design and boot model
  // ****************************************************************
  initial forever #2.5 ref_clk = ~ref_clk;
  spl_sys_pll_ctl dut_u (.*);
  spl_boot_model bm_u (.*);
  // Hang guard well past the longest expected run
  initial
  begin
    #40000;
    mismatches++;
    summarize();
  end
  task summarize();
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // One APB transfer; read data and error taken at the pready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1;
    @(posedge ref_clk);
    #1 chk("lol_reset", 1, lol_alarm);
    chk("div_reset", 10'h06c, pll_fbdiv);
    repeat (240) @(posedge ref_clk);
    chk("boot_div", 10'h0c8, pll_fbdiv);
    chk("boot_dbl", 1, pll_doubler_en);
    chk("boot_freq", 64'h0000_1234_5678_0009, {pll_freq_num, pll_freq_den});
    chk("locked", 0, lol_alarm);
    apb(0, spl_pkg::ADDR_STATUS, 0);
    chk("status", 4'h5, rd_v[3:0]);
    apb(1, spl_pkg::ADDR_IRQ_ST, 32'h0000_000f);
    apb(1, spl_pkg::ADDR_GPO_CFG, 32'h1);
    vc_set <= 12'h1ea;
    repeat (8) @(posedge ref_clk);
    chk("lol_out", 1, lol_alarm);
    chk("gpo_lol", 1, gpo_lol);
    chk("irq_masked", 0, irq);
    apb(1, spl_pkg::ADDR_IRQ_MSK, 32'h1);
    #1 chk("irq_on", 1, irq);
    apb(0, spl_pkg::ADDR_STATUS, 0);
    chk("status_loss", 2'h2, rd_v[1:0]);
    vc_set <= 12'h1e9;
    repeat (8) @(posedge ref_clk);
    chk("lol_edge", 0, lol_alarm);
    apb(1, spl_pkg::ADDR_IRQ_ST, 32'h0000_000f);
    #1 chk("irq_clr", 0, irq);
    apb(1, spl_pkg::ADDR_CTRL, 32'h0000_0320);
    #1 chk("stage_only", 10'h0c8, pll_fbdiv);
    apb(1, spl_pkg::ADDR_FREQ_LO, 32'h89ab_cdef);
    apb(1, spl_pkg::ADDR_FREQ_HI, 32'h0007_4567);
    exp_div = 10'h0c8;
    foreach (divs[i])
    begin
      apb(1, spl_pkg::ADDR_CTRL, {21'h100000, divs[i], i[0]});
      if (divs[i] >= 10'd108 && divs[i] <= 10'd556)
        exp_div = divs[i];
      #1 chk("apply_div", exp_div, pll_fbdiv);
      repeat (240) @(posedge ref_clk);
    end
    chk("apply_dbl", 1, pll_doubler_en);
    chk("apply_freq", 64'h4567_89ab_cdef_0007, {pll_freq_num, pll_freq_den});
    apb(0, spl_pkg::ADDR_IRQ_ST, 0);
    chk("bad_div_ev", 1, rd_v[2]);
    apb(0, 8'h40, 0);
    chk("unmapped", 0, rd_v);
    chk("unmapped_err", 0, err_v);
    src_mode <= 2'h2;
    rst_n <= 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1;
    repeat (240) @(posedge ref_clk);
    chk("eep_div", 10'h190, pll_fbdiv);
    apb(0, spl_pkg::ADDR_STATUS, 0);
    chk("eep_src", 1, rd_v[3]);
    // No usable store: reset defaults stay and the event is flagged
    src_mode <= 2'h0;
    rst_n <= 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1;
    repeat (240) @(posedge ref_clk);
    chk("nosrc_div", 10'h06c, pll_fbdiv);
    apb(0, spl_pkg::ADDR_IRQ_ST, 0);
    chk("nosrc_ev", 1, rd_v[3]);
    summarize();
  end
endmodule // system_pll_config_lock_monitor_tb
